// ==== logic/touch_event_qualifier_defines.vh ====
// Purpose: Constants for the touch event qualifier
// Assumes: Included by touch_event_qualifier.v only
// Notes:   Offsets are byte addresses of the serial register space
`ifndef TOUCH_EVENT_QUALIFIER_DEFINES_VH
`define TOUCH_EVENT_QUALIFIER_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_STATUS        8'h00
`define OFS_TOUCH_STATUS  8'h03
`define OFS_IRQ_EN        8'h27
`define OFS_REPEAT_EN     8'h28
`define OFS_GUARD_EN      8'h29
`define OFS_SIMUL_CFG     8'h2a
`define OFS_PATTERN_CFG   8'h2b
`define OFS_PATTERN_MASK  8'h2d
`define OFS_MISC_CFG      8'h3c

// ****************************************
// Reset values
// ****************************************
`define RST_IRQ_EN        8'h3f
`define RST_REPEAT_EN     8'h3f
`define RST_GUARD_EN      8'h00
`define RST_SIMUL_CFG     8'h80
`define RST_PATTERN_CFG   8'h00
`define RST_PATTERN_MASK  8'h3f
`define RST_MISC_CFG      8'h01

// ****************************************
// Field positions and masks
// ****************************************
`define CH_MASK           8'h3f
`define GUARD_MASK        8'h3b
`define CH3_BIT           6'h04
`define SIMUL_CFG_MASK    8'h8c
`define PATTERN_CFG_MASK  8'h8f
`define SIMUL_BLK_BIT     7
`define SIMUL_LIMIT_HI    3
`define SIMUL_LIMIT_LO    2
`define PAT_EN_BIT        7
`define PAT_TH_HI         3
`define PAT_TH_LO         2
`define PAT_MATCH_BIT     1
`define PAT_IRQ_BIT       0
`define STAT_INT_BIT      0
`define STAT_SIMUL_BIT    1
`define STAT_PATTERN_BIT  2
`define MISC_REL_BIT      0

// ****************************************
// Threshold scale codes
// ****************************************
`define TH_12P5           2'h0
`define TH_25             2'h1
`define TH_37P5           2'h2
`define TH_100            2'h3

`endif

// ==== logic/touch_event_qualifier.v ====
// Purpose: Qualify six channel touch results into host events and alert
// Assumes: Sensing results, thresholds and ticks come from logic on clk
// Notes:   Serial host link is outside; registers reached on a plain port
`timescale 1ns/1ps
`include "touch_event_qualifier_defines.vh"

module touch_event_qualifier (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire        cycle_done,
  input  wire [5:0]  touch_detect,
  input  wire [5:0]  noise_flag,
  input  wire [47:0] delta_count,
  input  wire [47:0] touch_threshold,
  input  wire        repeat_tick,
  output reg         alert_n,
  output reg         channel_three_off
);

  // ****************************************
  // Functions
  // ****************************************
  function [2:0] popcount;
    input [5:0] v;
    integer i;
    begin
      popcount = 3'h0;
      for (i = 0; i < 6; i = i + 1) begin
        popcount = popcount + {2'h0, v[i]};
      end
    end
  endfunction

  function [7:0] scale_th;
    input [7:0] th;
    input [1:0] code;
    begin
      case (code)
        `TH_12P5: scale_th = {3'h0, th[7:3]};
        `TH_25:   scale_th = {2'h0, th[7:2]};
        `TH_37P5: scale_th = {2'h0, th[7:2]} + {3'h0, th[7:3]};
        default:  scale_th = th;
      endcase
    end
  endfunction

  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Adds candidates from channel 1 upward until limit is reached
  function [5:0] fill_slots;
    input [5:0] base;
    input [5:0] cand;
    input [2:0] limit;
    integer i;
    reg [2:0] n;
    begin
      n = popcount(base);
      fill_slots = base;
      for (i = 0; i < 6; i = i + 1) begin
        if (cand[i] && !base[i] && (n < limit)) begin
          fill_slots[i] = 1'b1;
          n = n + 3'h1;
        end
      end
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] irq_en_q;
  reg  [7:0] repeat_en_q;
  reg  [7:0] guard_en_q;
  reg  [7:0] simul_cfg_q;
  reg  [7:0] pattern_cfg_q;
  reg  [7:0] pattern_mask_q;
  reg  [7:0] misc_cfg_q;
  reg        int_flag_q;
  reg        simul_flag_q;
  reg        pattern_flag_q;
  reg        pattern_active_q;
  reg  [5:0] reported_q;

  wire       guard_on            = |guard_en_q[5:0];
  wire       simul_block_enable  = simul_cfg_q[`SIMUL_BLK_BIT];
  wire [2:0] simul_touch_limit   = {1'b0, simul_cfg_q[`SIMUL_LIMIT_HI:`SIMUL_LIMIT_LO]} + 3'h1;
  wire       pattern_detect_enable = pattern_cfg_q[`PAT_EN_BIT];
  wire [1:0] pattern_threshold_code = pattern_cfg_q[`PAT_TH_HI:`PAT_TH_LO];
  wire       pattern_match_mode  = pattern_cfg_q[`PAT_MATCH_BIT];
  wire       pattern_irq_enable  = pattern_cfg_q[`PAT_IRQ_BIT];
  wire       release_irq_enable  = misc_cfg_q[`MISC_REL_BIT];
  wire [5:0] ch_off              = guard_on ? `CH3_BIT : 6'h00;

  // ****************************************
  // Pattern condition
  // ****************************************
  reg  [5:0] pat_hit;
  reg        pat_cond;
  integer    k;

  always @* begin
    pat_hit = 6'h00;
    for (k = 0; k < 6; k = k + 1) begin
      pat_hit[k] = (delta_count[k*8 +: 8] >
                    scale_th(touch_threshold[k*8 +: 8], pattern_threshold_code))
                   | noise_flag[k];
    end
    pat_hit = pat_hit & ~ch_off;
    // An empty mask never forms a pattern, so count mode cannot fire idly
    if (!pattern_detect_enable || pattern_mask_q[5:0] == 6'h00) begin
      pat_cond = 1'b0;
    end else if (pattern_match_mode) begin
      pat_cond = ((pat_hit & pattern_mask_q[5:0]) == pattern_mask_q[5:0]);
    end else begin
      pat_cond = (popcount(pat_hit) >= popcount(pattern_mask_q[5:0]));
    end
  end

  // ****************************************
  // Touch qualification
  // ****************************************
  reg  [5:0] det;
  reg  [5:0] kept;
  reg  [5:0] report_d;

  always @* begin
    det  = touch_detect & ~ch_off;
    kept = reported_q & det;
    if (pat_cond) begin
      report_d = 6'h00;
    end else if (!simul_block_enable) begin
      report_d = det;
    end else if (kept != reported_q) begin
      report_d = fill_slots(6'h00, det, simul_touch_limit);
    end else begin
      report_d = fill_slots(kept, det, simul_touch_limit);
    end
  end

  wire [5:0] press_ev   = report_d & ~reported_q;
  wire [5:0] release_ev = reported_q & ~report_d;
  wire [5:0] ch_event   = cycle_done ?
                          (press_ev | (release_ev & {6{release_irq_enable}}))
                          : 6'h00;
  wire [5:0] rpt_event  = repeat_tick ? (reported_q & repeat_en_q[5:0]) : 6'h00;
  wire       touch_irq  = |((ch_event | rpt_event) & irq_en_q[5:0]);
  wire       pat_event  = cycle_done && pat_cond;
  wire       simul_set  = cycle_done && simul_block_enable && !pat_cond &&
                          (det & ~report_d) != 6'h00;
  wire       int_set    = touch_irq || (pat_event && pattern_irq_enable);
  wire       wr_status  = wr_hit(reg_wr, reg_addr, `OFS_STATUS);
  wire       int_clr    = wr_status && !reg_wdata[`STAT_INT_BIT];

  // ****************************************
  // Next values
  // ****************************************
  reg        int_flag_d;
  reg        simul_flag_d;
  reg        pattern_flag_d;
  reg  [7:0] rdata_d;

  // Set wins over a clear in the same cycle so no event is lost
  always @* begin
    int_flag_d = int_flag_q;
    if (int_set) begin
      int_flag_d = 1'b1;
    end else if (int_clr) begin
      int_flag_d = 1'b0;
    end
  end

  always @* begin
    simul_flag_d = simul_flag_q;
    if (simul_set) begin
      simul_flag_d = 1'b1;
    end else if (int_clr) begin
      simul_flag_d = 1'b0;
    end
  end

  // A clear that meets a still-held pattern is ignored; the host retries
  always @* begin
    pattern_flag_d = pattern_flag_q;
    if (pat_event) begin
      pattern_flag_d = 1'b1;
    end else if (int_clr && !pattern_active_q) begin
      pattern_flag_d = 1'b0;
    end
  end

  always @* begin
    case (reg_addr)
      `OFS_STATUS:       rdata_d = {5'h00, pattern_flag_q, simul_flag_q, int_flag_q};
      `OFS_TOUCH_STATUS: rdata_d = {2'h0, reported_q};
      `OFS_IRQ_EN:       rdata_d = irq_en_q;
      `OFS_REPEAT_EN:    rdata_d = repeat_en_q;
      `OFS_GUARD_EN:     rdata_d = guard_en_q;
      `OFS_SIMUL_CFG:    rdata_d = simul_cfg_q;
      `OFS_PATTERN_CFG:  rdata_d = pattern_cfg_q;
      `OFS_PATTERN_MASK: rdata_d = pattern_mask_q;
      `OFS_MISC_CFG:     rdata_d = misc_cfg_q;
      default:           rdata_d = 8'h00;
    endcase
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= `RST_IRQ_EN;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_IRQ_EN)) begin
      irq_en_q <= reg_wdata & `CH_MASK;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      repeat_en_q <= `RST_REPEAT_EN;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_REPEAT_EN)) begin
      repeat_en_q <= reg_wdata & `CH_MASK;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_en_q <= `RST_GUARD_EN;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_GUARD_EN)) begin
      guard_en_q <= reg_wdata & `GUARD_MASK;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      simul_cfg_q <= `RST_SIMUL_CFG;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_SIMUL_CFG)) begin
      simul_cfg_q <= reg_wdata & `SIMUL_CFG_MASK;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pattern_cfg_q <= `RST_PATTERN_CFG;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_PATTERN_CFG)) begin
      pattern_cfg_q <= reg_wdata & `PATTERN_CFG_MASK;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pattern_mask_q <= `RST_PATTERN_MASK;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_PATTERN_MASK)) begin
      pattern_mask_q <= reg_wdata & `CH_MASK;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      misc_cfg_q <= `RST_MISC_CFG;
    end else if (ce && wr_hit(reg_wr, reg_addr, `OFS_MISC_CFG)) begin
      misc_cfg_q <= {7'h00, reg_wdata[`MISC_REL_BIT]};
    end
  end

  // ****************************************
  // Sensing state
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reported_q       <= 6'h00;
      pattern_active_q <= 1'b0;
    end else if (ce && cycle_done) begin
      reported_q       <= report_d;
      pattern_active_q <= pat_cond;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_flag_q <= 1'b0;
    end else if (ce) begin
      int_flag_q <= int_flag_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      simul_flag_q <= 1'b0;
    end else if (ce) begin
      simul_flag_q <= simul_flag_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pattern_flag_q <= 1'b0;
    end else if (ce) begin
      pattern_flag_q <= pattern_flag_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Alert follows the next flag value, so it falls at the event edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alert_n <= 1'b1;
    end else if (ce) begin
      alert_n <= !int_flag_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_three_off <= 1'b0;
    end else if (ce) begin
      channel_three_off <= guard_on;
    end
  end

  // Read data holds between reads
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// ==== verification/sense_front.sv ====
// Purpose: Sensing front end model, one result per request
// Assumes: Requests change on the falling clock edge
// Notes:   Outside the result cycle the data lines carry junk on purpose
`timescale 1ns/1ps
module sense_front (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [3:0]  lag,
  input  wire logic [5:0]  hits,
  input  wire logic [5:0]  noise,
  input  wire logic [47:0] delta,
  output logic             cycle_done,
  output logic             busy,
  output logic [5:0]       touch_detect,
  output logic [5:0]       noise_flag,
  output logic [47:0]      delta_count,
  output logic [47:0]      touch_threshold
);
  initial begin
    {cycle_done, busy, touch_detect, noise_flag, delta_count} = '0;
    touch_threshold = {6{8'h40}};
    forever begin
      @(posedge clk);
      if (go) begin
        busy = 1'b1;
        repeat (lag + 1) @(negedge clk);
        {cycle_done, touch_detect, noise_flag, delta_count} = {1'b1, hits, noise, delta};
        @(negedge clk);
        // Inverted so a stale sample can never look valid
        {cycle_done, touch_detect, noise_flag, delta_count} = {1'b0, ~hits, ~noise, ~delta};
        @(posedge clk);
        busy = 1'b0;
      end
    end
  end
endmodule

// ==== verification/touch_event_qualifier_asserts.sv ====
// Purpose: Port assertions for the touch event qualifier
// Assumes: One clock; gating registers shadowed from writes
// Notes:   Counts and blocking are left to the bench
`timescale 1ns/1ps
module touch_event_qualifier_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       reg_wr,
  input wire logic       cycle_done,
  input wire logic       repeat_tick,
  input wire logic       alert_n,
  input wire logic       channel_three_off,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [5:0] touch_detect
);
  logic [5:0] ien_q, prev_q;
  logic [7:0] pcfg_q;
  logic       gq_q;
  wire        wr0 = ce && reg_wr && reg_addr == 8'h00;
  wire        evt = ce && (cycle_done || repeat_tick);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {ien_q, prev_q, pcfg_q, gq_q} <= {6'h3f, 6'h00, 8'h00, 1'b0};
    end else if (ce) begin
      if (reg_wr && reg_addr == 8'h27) ien_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == 8'h2b) pcfg_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h29) gq_q <= |(reg_wdata & 8'h3b);
      if (cycle_done) prev_q <= touch_detect;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  chk_guard_gate: assert property (
    (ce && $stable(gq_q)) [*3] |-> channel_three_off == gq_q) else $error("guard gate");
  chk_clear_alert: assert property (
    wr0 && !reg_wdata[0] && !evt |=> alert_n) else $error("alert not cleared");
  chk_alert_holds: assert property (
    !alert_n && !wr0 |=> !alert_n) else $error("alert dropped");
  chk_alert_cause: assert property (
    $fell(alert_n) |-> $past(evt)) else $error("alert without event");
  chk_masked_quiet: assert property (
    alert_n && ien_q == 6'h00 && !pcfg_q[0] |=> alert_n) else $error("masked alert");
  chk_press_alert: assert property (
    evt && cycle_done && touch_detect[0] && ien_q[0] && prev_q == 6'h00 && !pcfg_q[7]
    |=> !alert_n) else $error("press without alert");
  chk_idle_quiet: assert property (
    evt && !repeat_tick && touch_detect == 6'h00 && prev_q == 6'h00 && !pcfg_q[7] && alert_n
    |=> alert_n) else $error("idle alert");
  chk_freeze_hold: assert property (
    !ce |=> $stable(alert_n) && $stable(channel_three_off)) else $error("not frozen");
  cover property (ce && cycle_done && touch_detect == 6'h3f);
  cover property (!alert_n ##1 alert_n);
  cover property (channel_three_off);
endmodule
bind touch_event_qualifier touch_event_qualifier_asserts u_chk (.clk, .rst, .ce, .reg_wr,
  .cycle_done, .repeat_tick, .alert_n, .channel_three_off, .reg_addr, .reg_wdata, .touch_detect);

// ==== verification/tb_touch_event_qualifier.sv ====
// Purpose: Self-checking bench for the touch event qualifier
// Assumes: Inputs change on the falling edge
// Notes:   Front end thresholds fixed at 0x40 per channel
`timescale 1ns/1ps
module tb_touch_event_qualifier;
  logic        clk, rst, ce, reg_wr, reg_rd, repeat_tick, go, busy, cycle_done;
  logic        alert_n, channel_three_off;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, th;
  logic [3:0]  lag;
  logic [5:0]  hits, noise, touch_detect, noise_flag;
  logic [47:0] delta, delta_count, touch_threshold;
  int          bad_count, total_checks, cyc;
  logic [7:0]  ofs [9] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2d, 8'h50, 8'h3c, 8'h00};
  logic [7:0]  rv  [9] = '{8'h3f, 8'h3f, 8'h00, 8'h80, 8'h00, 8'h3f, 8'h00, 8'h01, 8'h00};
  touch_event_qualifier dut (.clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .cycle_done, .touch_detect, .noise_flag, .delta_count, .touch_threshold,
    .repeat_tick, .alert_n, .channel_three_off);
  sense_front u_sense (.clk, .go, .lag, .hits, .noise, .delta, .cycle_done, .busy,
    .touch_detect, .noise_flag, .delta_count, .touch_threshold);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Run needs about 300 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle after each strobe so no signal is set twice in one step
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 1'b0;
    chk(reg_rdata, e);
    @(negedge clk);
  endtask
  task automatic s(input logic [5:0] h, input logic [5:0] n, input logic [47:0] dl);
    {go, hits, noise, delta} = {1'b1, h, n, dl};
    @(negedge clk) go = 1'b0;
    while (busy) @(negedge clk);
  endtask
  task automatic tick;
    repeat_tick = 1'b1;
    @(negedge clk) repeat_tick = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    {rst, ce, reg_wr, reg_rd, repeat_tick, go, lag} = {6'b110000, 4'h0};
    {reg_addr, reg_wdata, hits, noise, delta} = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    foreach (ofs[i]) r(ofs[i], rv[i]);
    w(8'h29, 8'hff);
    r(8'h29, 8'h3b);
    chk({7'h0, channel_three_off}, 8'h01);
    s(6'h04, 6'h00, '0);
    r(8'h03, 8'h00);
    w(8'h29, 8'h04);
    chk({7'h0, channel_three_off}, 8'h00);
    s(6'h01, 6'h00, '0);
    chk({7'h0, alert_n}, 8'h00);
    w(8'h00, 8'h00);
    chk({7'h0, alert_n}, 8'h01);
    tick();
    chk({7'h0, alert_n}, 8'h00);
    w(8'h00, 8'h00);
    w(8'h28, 8'h00);
    tick();
    s(6'h01, 6'h00, '0);
    chk({7'h0, alert_n}, 8'h01);
    s(6'h00, 6'h00, '0);
    chk({7'h0, alert_n}, 8'h00);
    w(8'h00, 8'h00);
    w(8'h27, 8'h00);
    s(6'h01, 6'h00, '0);
    r(8'h03, 8'h01);
    chk({7'h0, alert_n}, 8'h01);
    s(6'h00, 6'h00, '0);
    w(8'h27, 8'h3f);
    w(8'h3c, 8'h00);
    s(6'h01, 6'h00, '0);
    w(8'h00, 8'h00);
    s(6'h00, 6'h00, '0);
    chk({7'h0, alert_n}, 8'h01);
    w(8'h3c, 8'h01);
    for (int i = 0; i < 4; i++) begin
      w(8'h2a, {4'h8, i[1:0], 2'b00});
      s(6'h3f, 6'h00, '0);
      r(8'h03, 8'h0f >> (3 - i));
      r(8'h00, 8'h03);
      s(6'h00, 6'h00, '0);
      w(8'h00, 8'h00);
    end
    w(8'h2a, 8'h80);
    s(6'h06, 6'h00, '0);
    r(8'h03, 8'h02);
    s(6'h05, 6'h00, '0);
    r(8'h03, 8'h01);
    w(8'h2a, 8'h00);
    w(8'h00, 8'h00);
    s(6'h3f, 6'h00, '0);
    r(8'h03, 8'h3f);
    r(8'h00, 8'h01);
    s(6'h00, 6'h00, '0);
    w(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      th = (i == 3) ? 8'h40 : 8'(8 * (i + 1));
      w(8'h2b, {4'h8, i[1:0], 2'b00});
      s(6'h00, 6'h00, {6{th + 8'h01}});
      w(8'h00, 8'h00);
      r(8'h00, 8'h04);
      s(6'h00, 6'h00, {6{th}});
      w(8'h00, 8'h00);
      r(8'h00, 8'h00);
    end
    w(8'h2d, 8'h03);
    w(8'h2b, 8'h83);
    s(6'h01, 6'h00, 48'h0909);
    r(8'h03, 8'h00);
    r(8'h00, 8'h05);
    w(8'h00, 8'h00);
    s(6'h01, 6'h00, 48'h0009);
    r(8'h03, 8'h01);
    w(8'h00, 8'h00);
    s(6'h00, 6'h03, '0);
    r(8'h00, 8'h05);
    s(6'h00, 6'h00, '0);
    w(8'h00, 8'h00);
    w(8'h2b, 8'h81);
    s(6'h00, 6'h30, '0);
    r(8'h00, 8'h05);
    s(6'h00, 6'h00, '0);
    w(8'h2b, 8'h01);
    w(8'h00, 8'h00);
    lag = 4'h3;
    s(6'h00, 6'h3f, '0);
    r(8'h00, 8'h00);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    complete_run();
  end
endmodule
